// ==== shared/ddc_pkg.sv ====
// constants for the dual converter control and data registers
// assumes an 8-bit special function register bus on the core clock
package ddc_pkg;

  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HIGH_NIB_W = 4;

  // register addresses in the special function register space
  localparam logic [7:0] ADDR_CH0_LOW = 8'hf9;
  localparam logic [7:0] ADDR_CH0_HIGH = 8'hfa;
  localparam logic [7:0] ADDR_CH1_LOW = 8'hfb;
  localparam logic [7:0] ADDR_CH1_HIGH = 8'hfc;
  localparam logic [7:0] ADDR_CONTROL = 8'hfd;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h04;
  localparam logic [7:0] RST_DATA = 8'h00;

  // converter_control field positions
  localparam int unsigned BIT_MODE8 = 7;
  localparam int unsigned BIT_SPAN_CH1 = 6;
  localparam int unsigned BIT_SPAN_CH0 = 5;
  localparam int unsigned BIT_ZERO_N_CH1 = 4;
  localparam int unsigned BIT_ZERO_N_CH0 = 3;
  localparam int unsigned BIT_SYNC = 2;
  localparam int unsigned BIT_PWR_CH1 = 1;
  localparam int unsigned BIT_PWR_CH0 = 0;

  // 8-bit codes are placed in the top of the 12-bit code
  localparam int unsigned MODE8_PAD_W = CODE_W - BYTE_W;

endpackage

// ==== hdl/ddc_channel.sv ====
// one converter channel: the active code and its output conditioning
// assumes load and the held bytes come from the register block, same clock
`timescale 1ns/100ps
module ddc_channel
#(
  parameter int unsigned CODE_W = ddc_pkg::CODE_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] low_byte,
  input wire logic [7:0] high_byte,
  input wire logic mode8,
  input wire logic zero_force_n,
  input wire logic power_on,
  output logic [CODE_W-1:0] active_code,
  output logic [CODE_W-1:0] drive_code,
  output logic out_enable
);

  typedef struct packed
  {
    logic [CODE_W-1:0] active;
    logic [CODE_W-1:0] drive;
    logic en;
  } ddc_chan_state_t;

  ddc_chan_state_t st;
  ddc_chan_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (load)
    begin
      if (mode8)
      begin
        // only the low byte counts in 8-bit operation
        next_st.active = {low_byte,
          {ddc_pkg::MODE8_PAD_W{1'b0}}};
      end
      else
      begin
        // right-justified: low byte, then high byte's low nibble
        next_st.active = {high_byte[ddc_pkg::HIGH_NIB_W-1:0], low_byte};
      end
    end
    // clearing only gates the drive; the held code survives
    if (!zero_force_n)
    begin
      next_st.drive = '0;
    end
    else
    begin
      next_st.drive = next_st.active;
    end
    // powered off means high impedance at the pin
    next_st.en = power_on;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign active_code = st.active;
  assign drive_code = st.drive;
  assign out_enable = st.en;

endmodule

// ==== hdl/ddc_regs.sv ====
// control and data registers of the dual 12-bit voltage converters
// assumes the core's special function register bus on ref_clk; writes
// and reads are single-cycle strobes, read data follow one cycle later
//
// Overview of operation
// - control bit 7 picks 8-bit (1) or 12-bit (0) width for both channels
// - control bit 6 picks channel 1 span: 1 supply, 0 reference
// - control bit 5 picks channel 0 span: 1 supply, 0 reference
// - control bit 4 low forces channel 1 output to zero volts
// - control bit 3 low forces channel 0 output to zero volts
// - bit 2 high: a channel updates right after its low byte is written
// - bit 2 low holds writes; its rise updates both channels together
// - control bit 1 powers channel 1 on when high
// - control bit 0 powers channel 0 on when high
// - all four data bytes reset to zero; no bit addressing
// - 12-bit code: low byte low 8 bits, high nibble upper 4 bits
// - after reset both channels are off with outputs high impedance
// - buffer bypass routes the unbuffered converter output to the pin
`timescale 1ns/100ps
module ddc_regs
#(
  parameter int unsigned CODE_W = ddc_pkg::CODE_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic buffer_bypass,
  output logic [CODE_W-1:0] ch0_code,
  output logic [CODE_W-1:0] ch1_code,
  output logic ch0_out_enable,
  output logic ch1_out_enable,
  output logic span_select_ch0,
  output logic span_select_ch1,
  output logic mode8,
  output logic buffer_bypass_en
);

  // every flop of the register side; the channel codes live per channel
  typedef struct packed
  {
    logic [7:0] control;
    logic [7:0] ch0_low;
    logic [7:0] ch0_high;
    logic [7:0] ch1_low;
    logic [7:0] ch1_high;
    logic [7:0] rdata;
    logic bypass;
  } ddc_reg_state_t;

  ddc_reg_state_t st;
  ddc_reg_state_t next_st;

  logic [1:0] load;
  logic [7:0] wr_low [2];
  logic [7:0] wr_high [2];
  logic [CODE_W-1:0] drive [2];
  logic [1:0] low_wr;
  logic [1:0] out_en;
  logic [1:0] zero_n;
  logic [1:0] pwr;

  // one decode for every register, used by writes, the hit flag and the load; reads use a case on the address
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  function automatic logic [7:0] low_addr(input int unsigned ch);
    low_addr = (ch == 0) ? ddc_pkg::ADDR_CH0_LOW : ddc_pkg::ADDR_CH1_LOW;
  endfunction

  logic ctl_wr;
  logic sync_rise;

  always_comb
  begin
    ctl_wr = sfr_wr && addr_hit(sfr_addr, ddc_pkg::ADDR_CONTROL);
    // synchronous transfer on the 0-to-1 edge of the update bit
    // rewriting the bit as 1 does not reload, so a new held pair needs
    // the bit cleared and set again
    sync_rise = ctl_wr && sfr_wdata[ddc_pkg::BIT_SYNC] &&
      !st.control[ddc_pkg::BIT_SYNC];
  end

  always_comb
  begin
    next_st = st;
    // bypass copy follows its config bit one clock later
    next_st.bypass = buffer_bypass;
    // whole-byte writes only
    if (sfr_wr)
    begin
      if (addr_hit(sfr_addr, ddc_pkg::ADDR_CONTROL))
      begin
        next_st.control = sfr_wdata;
      end
      if (addr_hit(sfr_addr, ddc_pkg::ADDR_CH0_LOW))
      begin
        next_st.ch0_low = sfr_wdata;
      end
      if (addr_hit(sfr_addr, ddc_pkg::ADDR_CH0_HIGH))
      begin
        next_st.ch0_high = sfr_wdata;
      end
      if (addr_hit(sfr_addr, ddc_pkg::ADDR_CH1_LOW))
      begin
        next_st.ch1_low = sfr_wdata;
      end
      if (addr_hit(sfr_addr, ddc_pkg::ADDR_CH1_HIGH))
      begin
        next_st.ch1_high = sfr_wdata;
      end
    end
    // unmapped addresses read as zero; a data byte reads back as stored,
    // not as driven, so a cleared channel still shows its programmed byte
    // and rdata holds the last read until the next read strobe
    if (sfr_rd)
    begin
      case (sfr_addr)
        ddc_pkg::ADDR_CONTROL: next_st.rdata = st.control;
        ddc_pkg::ADDR_CH0_LOW: next_st.rdata = st.ch0_low;
        ddc_pkg::ADDR_CH0_HIGH: next_st.rdata = st.ch0_high;
        ddc_pkg::ADDR_CH1_LOW: next_st.rdata = st.ch1_low;
        ddc_pkg::ADDR_CH1_HIGH: next_st.rdata = st.ch1_high;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // power-on values: update bit set, channels off
      // rdata and bypass copy clear too, so nothing stale leaves the block
      st.control <= ddc_pkg::RST_CONTROL;
      st.ch0_low <= ddc_pkg::RST_DATA;
      st.ch0_high <= ddc_pkg::RST_DATA;
      st.ch1_low <= ddc_pkg::RST_DATA;
      st.ch1_high <= ddc_pkg::RST_DATA;
      st.rdata <= 8'h00;
      st.bypass <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    // the channel sees the bytes as they stand after this cycle's write,
    // so an immediate update carries the byte just written
    wr_low[0] = next_st.ch0_low;
    wr_high[0] = next_st.ch0_high;
    wr_low[1] = next_st.ch1_low;
    wr_high[1] = next_st.ch1_high;
    zero_n[0] = st.control[ddc_pkg::BIT_ZERO_N_CH0];
    zero_n[1] = st.control[ddc_pkg::BIT_ZERO_N_CH1];
    pwr[0] = st.control[ddc_pkg::BIT_PWR_CH0];
    pwr[1] = st.control[ddc_pkg::BIT_PWR_CH1];
  end

  // high byte alone never moves the output; software orders the bytes
  // so the pair is consistent when the low byte lands
  // a loaded code is not reformatted by a later mode change: the width
  // is taken at load time, so software rewrites the low byte after it
  always_comb
  begin
    for (int ch = 0; ch < ddc_pkg::NUM_CH; ch++)
    begin
      low_wr[ch] = sfr_wr && addr_hit(sfr_addr, low_addr(ch));
      // immediate update on a low-byte write while the bit is high
      load[ch] = (low_wr[ch] && st.control[ddc_pkg::BIT_SYNC]) ||
        sync_rise;
    end
  end

  // one conditioning stage per channel; its code register is the
  // active code, the byte registers here are what software wrote
  for (genvar ch = 0; ch < ddc_pkg::NUM_CH; ch++)
  begin : g_ch
    ddc_channel #(
      .CODE_W(CODE_W)
    ) u_chan (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(load[ch]),
      .low_byte(wr_low[ch]),
      .high_byte(wr_high[ch]),
      .mode8(st.control[ddc_pkg::BIT_MODE8]),
      .zero_force_n(zero_n[ch]),
      .power_on(pwr[ch]),
      .active_code(),
      .drive_code(drive[ch]),
      .out_enable(out_en[ch])
    );
  end

  assign sfr_rdata = st.rdata;
  // address match for the core's read mux; needs no strobe
  assign sfr_hit = addr_hit(sfr_addr, ddc_pkg::ADDR_CONTROL) ||
    addr_hit(sfr_addr, ddc_pkg::ADDR_CH0_LOW) ||
    addr_hit(sfr_addr, ddc_pkg::ADDR_CH0_HIGH) ||
    addr_hit(sfr_addr, ddc_pkg::ADDR_CH1_LOW) ||
    addr_hit(sfr_addr, ddc_pkg::ADDR_CH1_HIGH);
  assign ch0_code = drive[0];
  assign ch1_code = drive[1];
  assign ch0_out_enable = out_en[0];
  assign ch1_out_enable = out_en[1];
  // span bits go straight to the converters' range switches
  assign span_select_ch0 = st.control[ddc_pkg::BIT_SPAN_CH0];
  assign span_select_ch1 = st.control[ddc_pkg::BIT_SPAN_CH1];
  assign mode8 = st.control[ddc_pkg::BIT_MODE8];
  // bypass does not check the span; software keeps them consistent
  assign buffer_bypass_en = st.bypass;

endmodule

// ==== verification/ddc_regs_sva.sv ====
// assertions on the converter register block ports
// assumes binding into every ddc_regs instance, single clock domain
`timescale 1ns/100ps
module ddc_regs_sva
#(
  parameter int unsigned CODE_W = ddc_pkg::CODE_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic buffer_bypass,
  input wire logic [CODE_W-1:0] ch0_code,
  input wire logic [CODE_W-1:0] ch1_code,
  input wire logic ch0_out_enable,
  input wire logic ch1_out_enable,
  input wire logic span_select_ch0,
  input wire logic span_select_ch1,
  input wire logic mode8,
  input wire logic buffer_bypass_en
);
  wire ctl_wr = sfr_wr && sfr_addr == ddc_pkg::ADDR_CONTROL;
  // shadow of what software wrote, so codes are predicted from the bus
  logic [7:0] ctl_seen;
  logic [7:0] lo0_seen;
  logic [7:0] hi0_seen;
  logic [7:0] lo1_seen;
  logic [7:0] hi1_seen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctl_seen <= ddc_pkg::RST_CONTROL;
      lo0_seen <= ddc_pkg::RST_DATA;
      hi0_seen <= ddc_pkg::RST_DATA;
      lo1_seen <= ddc_pkg::RST_DATA;
      hi1_seen <= ddc_pkg::RST_DATA;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == ddc_pkg::ADDR_CONTROL)
        ctl_seen <= sfr_wdata;
      if (sfr_addr == ddc_pkg::ADDR_CH0_LOW)
        lo0_seen <= sfr_wdata;
      if (sfr_addr == ddc_pkg::ADDR_CH0_HIGH)
        hi0_seen <= sfr_wdata;
      if (sfr_addr == ddc_pkg::ADDR_CH1_LOW)
        lo1_seen <= sfr_wdata;
      if (sfr_addr == ddc_pkg::ADDR_CH1_HIGH)
        hi1_seen <= sfr_wdata;
    end
  end
  a_mode_width:
    assert property (ctl_wr |=>
      mode8 == $past(sfr_wdata[ddc_pkg::BIT_MODE8]))
      else $error("mode8 wrong");
  a_span_one:
    assert property (ctl_wr |=>
      span_select_ch1 == $past(sfr_wdata[ddc_pkg::BIT_SPAN_CH1]))
      else $error("span1 wrong");
  a_span_zero:
    assert property (ctl_wr |=>
      span_select_ch0 == $past(sfr_wdata[ddc_pkg::BIT_SPAN_CH0]))
      else $error("span0 wrong");
  a_clear_one:
    assert property (ctl_wr && !sfr_wdata[ddc_pkg::BIT_ZERO_N_CH1] |->
      ##2 ch1_code == '0) else $error("ch1 not zeroed");
  a_clear_zero:
    assert property (ctl_wr && !sfr_wdata[ddc_pkg::BIT_ZERO_N_CH0] |->
      ##2 ch0_code == '0) else $error("ch0 not zeroed");
  a_power_one:
    assert property (ctl_wr |-> ##2
      ch1_out_enable == $past(sfr_wdata[ddc_pkg::BIT_PWR_CH1], 2))
      else $error("en1 wrong");
  a_power_zero:
    assert property (ctl_wr |-> ##2
      ch0_out_enable == $past(sfr_wdata[ddc_pkg::BIT_PWR_CH0], 2))
      else $error("en0 wrong");
  a_immediate_ch0:
    assert property (sfr_wr && sfr_addr == ddc_pkg::ADDR_CH0_LOW &&
      ctl_seen[ddc_pkg::BIT_SYNC] && ctl_seen[ddc_pkg::BIT_ZERO_N_CH0] &&
      !ctl_seen[ddc_pkg::BIT_MODE8] |=> ch0_code ==
      {$past(hi0_seen[ddc_pkg::HIGH_NIB_W-1:0]), $past(sfr_wdata)})
      else $error("ch0 immediate load wrong");
  a_immediate_ch1:
    assert property (sfr_wr && sfr_addr == ddc_pkg::ADDR_CH1_LOW &&
      ctl_seen[ddc_pkg::BIT_SYNC] && ctl_seen[ddc_pkg::BIT_ZERO_N_CH1] &&
      !ctl_seen[ddc_pkg::BIT_MODE8] |=> ch1_code ==
      {$past(hi1_seen[ddc_pkg::HIGH_NIB_W-1:0]), $past(sfr_wdata)})
      else $error("ch1 immediate load wrong");
  a_sync_both:
    assert property (ctl_wr && sfr_wdata[ddc_pkg::BIT_SYNC] &&
      !ctl_seen[ddc_pkg::BIT_SYNC] && !ctl_seen[ddc_pkg::BIT_MODE8] &&
      ctl_seen[ddc_pkg::BIT_ZERO_N_CH0] &&
      ctl_seen[ddc_pkg::BIT_ZERO_N_CH1] |=>
      ch0_code == {$past(hi0_seen[ddc_pkg::HIGH_NIB_W-1:0]),
        $past(lo0_seen)} &&
      ch1_code == {$past(hi1_seen[ddc_pkg::HIGH_NIB_W-1:0]),
        $past(lo1_seen)})
      else $error("simultaneous load wrong");
  a_held_quiet:
    assert property (sfr_wr && sfr_addr == ddc_pkg::ADDR_CH0_LOW &&
      !ctl_seen[ddc_pkg::BIT_SYNC] && ctl_seen[ddc_pkg::BIT_ZERO_N_CH0] &&
      $past(ctl_seen[ddc_pkg::BIT_ZERO_N_CH0]) |=> $stable(ch0_code))
      else $error("ch0 moved while held");
  a_unmapped_read:
    assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
      else $error("unmapped read");
  a_bypass_copy:
    assert property (rst_n |=> buffer_bypass_en == $past(buffer_bypass))
      else $error("bypass lag");
  a_reset_off:
    assert property (disable iff (1'b0) !rst_n |=> !ch0_out_enable && !ch1_out_enable)
      else $error("enabled in reset");
endmodule

bind ddc_regs ddc_regs_sva #(.CODE_W(CODE_W)) u_sva (.ref_clk(ref_clk),
  .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .buffer_bypass(buffer_bypass), .ch0_code(ch0_code), .ch1_code(ch1_code),
  .ch0_out_enable(ch0_out_enable), .ch1_out_enable(ch1_out_enable),
  .span_select_ch0(span_select_ch0), .span_select_ch1(span_select_ch1),
  .mode8(mode8), .buffer_bypass_en(buffer_bypass_en));

// ==== verification/ddc_regs_tb.sv ====
// self-checking bench for the converter register block
// assumes fixed latencies: store and loaded code at write edge, clear and power one cycle later
`timescale 1ns/100ps
module ddc_regs_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic buffer_bypass = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [11:0] ch0_code;
  logic [11:0] ch1_code;
  logic ch0_out_enable;
  logic ch1_out_enable;
  logic span_select_ch0;
  logic span_select_ch1;
  logic mode8;
  logic buffer_bypass_en;
  int miscompares = 0;
  int n_compared = 0;
  // control value beside {mode8, span1, span0, en1, en0}
  logic [12:0] rows [6] = '{{8'h80, 5'h10}, {8'h40, 5'h08}, {8'h20, 5'h04},
    {8'h02, 5'h02}, {8'h01, 5'h01}, {8'h00, 5'h00}};
  wire [11:0] flags = {7'h00, mode8, span_select_ch1, span_select_ch0,
    ch1_out_enable, ch0_out_enable};

  ddc_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .buffer_bypass(buffer_bypass),
    .ch0_code(ch0_code), .ch1_code(ch1_code),
    .ch0_out_enable(ch0_out_enable), .ch1_out_enable(ch1_out_enable),
    .span_select_ch0(span_select_ch0), .span_select_ch1(span_select_ch1),
    .mode8(mode8), .buffer_bypass_en(buffer_bypass_en));

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [11:0] seen,
    input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobe dropped for one idle cycle so it is never set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk("rdata", {4'h0, sfr_rdata}, {4'h0, exp});
    chk("hit", {11'h000, sfr_hit}, {11'h000,
      a >= ddc_pkg::ADDR_CH0_LOW && a <= ddc_pkg::ADDR_CONTROL});
    @(negedge ref_clk);
  endtask

  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("rst_flags", flags, 12'h000);
    chk("rst_bypass", {11'h000, buffer_bypass_en}, 12'h000);
    chk("rst_code", ch0_code | ch1_code, 12'h000);
    for (int a = 8'hf8; a <= 8'hfd; a++)
      rd(a[7:0], a == 8'hfd ? 8'h04 : 8'h00);
    foreach (rows[i])
    begin
      wr(8'hfd, rows[i][12:5]);
      chk("flags", flags, {7'h00, rows[i][4:0]});
      rd(8'hfd, rows[i][12:5]);
    end
    wr(8'hfd, 8'h1f);
    wr(8'hfa, 8'hfa);
    wr(8'hf9, 8'hbc);
    chk("ch0", ch0_code, 12'habc);
    wr(8'hfc, 8'h05);
    wr(8'hfb, 8'h67);
    chk("ch1", ch1_code, 12'h567);
    wr(8'hfd, 8'h1b);
    wr(8'hf9, 8'h11);
    wr(8'hfb, 8'h22);
    chk("held0", ch0_code, 12'habc);
    chk("held1", ch1_code, 12'h567);
    wr(8'hfd, 8'h1f);
    chk("sync0", ch0_code, 12'ha11);
    chk("sync1", ch1_code, 12'h522);
    @(negedge ref_clk);
    wr(8'hfd, 8'h07);
    @(negedge ref_clk);
    chk("clr", ch0_code | ch1_code, 12'h000);
    wr(8'hfd, 8'h1f);
    @(negedge ref_clk);
    chk("keep0", ch0_code, 12'ha11);
    chk("keep1", ch1_code, 12'h522);
    rd(8'hf9, 8'h11);
    wr(8'hfd, 8'h9f);
    wr(8'hf9, 8'h5a);
    chk("ch0_8b", ch0_code, 12'h5a0);
    buffer_bypass = 1'b1;
    @(negedge ref_clk);
    chk("bypass", {11'h000, buffer_bypass_en}, 12'h001);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("rst2_flags", flags, 12'h000);
    chk("rst2_code", ch0_code | ch1_code, 12'h000);
    chk("rst2_bypass", {11'h000, buffer_bypass_en}, 12'h000);
    rd(8'hfd, 8'h04);
    rd(8'hf9, 8'h00);
    rd(8'hfb, 8'h00);
    complete_run();
  end
endmodule
